// ### rtl/balu_core.sv
// ALU datapath: byte, word and multiply operations with flag updates.
`default_nettype none
// Contract
// [RULE_01] Add registers, optional carry, one cycle
// [RULE_02] Subtract registers, optional carry, one cycle
// [RULE_03] Subtract constant, optional carry, one cycle
// [RULE_04] Add constant to register pair, two cycles
// [RULE_05] Subtract constant from register pair, two cycles
// [RULE_06] AND register or constant, Z N V
// [RULE_07] OR and exclusive-OR, Z N V
// [RULE_08] Test register, value kept, Z N V
// [RULE_09] Set bits: OR in constant mask
// [RULE_10] Clear bits: AND with ones minus mask
// [RULE_11] Multiply three signedness forms, product pair
// [RULE_12] Fractional multiply shifts product left one
// [RULE_13] Invert and negate register, one cycle
// [RULE_14] Increment, decrement keep carry untouched
// [RULE_15] Zero register flags; all-ones keeps flags
module balu_core
   import balu_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic [4:0] op_i,
   input wire logic [7:0] dest_i,
   input wire logic [7:0] source_i,
   input wire logic [7:0] pair_high_i,
   input wire logic [7:0] flags_i,
   output logic [7:0] result_o,
   output logic [7:0] result_high_o,
   output logic [7:0] flags_o,
   output logic write_dest_o,
   output logic write_pair_o,
   output logic write_product_o,
   output logic flags_write_o,
   output logic busy_o,
   output logic done_o
);
   // ==========================================================
   // All state of the block in one record.
   typedef struct packed
   {
      balu_state_t st;
      logic [4:0] op;
      logic [7:0] a, b, hi, fin;
      logic [7:0] res, res_hi, flags;
      logic wr_dest, wr_pair, wr_prod, flags_we, done;
   } balu_reg_t;

   balu_reg_t cur, next_cur;
   logic [4:0] op;
   logic [7:0] a, b, hi, fin;
   logic [15:0] prod;
   logic two_cycle, prod_c, prod_z, m_as, m_bs, m_fr;

   // ==========================================================
   // Operands come from the record on the second cycle of a two-cycle
   // operation, so a refused start cannot disturb them.
   assign op = busy_o ? cur.op : op_i;
   assign a = busy_o ? cur.a : dest_i;
   assign b = busy_o ? cur.b : source_i;
   assign hi = busy_o ? cur.hi : pair_high_i;
   assign fin = busy_o ? cur.fin : flags_i;

   // Word and multiply operations need a second cycle.
   assign two_cycle = (op >= OP_ADD_IMMEDIATE_TO_PAIR);
   assign m_as = (op == OP_MULTIPLY_SIGNED) ||
                 (op == OP_MULTIPLY_SIGNED_BY_UNSIGNED) ||
                 (op == OP_FRACTIONAL_MULTIPLY_SIGNED) ||
                 (op == OP_FRACTIONAL_MULTIPLY_MIXED);
   assign m_bs = (op == OP_MULTIPLY_SIGNED) ||
                 (op == OP_FRACTIONAL_MULTIPLY_SIGNED);
   assign m_fr = (op >= OP_FRACTIONAL_MULTIPLY_UNSIGNED);

   balu_mult u_mult
   (
      .a_i(a),
      .b_i(b),
      .a_signed_i(m_as),
      .b_signed_i(m_bs),
      .frac_i(m_fr),
      .product_o(prod),
      .carry_o(prod_c),
      .zero_o(prod_z)
   );

   // ==========================================================
   // Next-state and datapath evaluation.
   always_comb
   begin
      logic [7:0] r, x, y;
      logic [15:0] w, pair;
      logic cin, chain, logic_op, sub_op, fire;
      r = BYTE_ZERO;
      x = BYTE_ZERO;
      y = BYTE_ZERO;
      w = WORD_ZERO;
      pair = {hi, a};
      cin = 1'b0;
      chain = 1'b0;
      logic_op = 1'b0;
      sub_op = 1'b0;
      next_cur = cur;
      next_cur.wr_dest = 1'b0;
      next_cur.wr_pair = 1'b0;
      next_cur.wr_prod = 1'b0;
      next_cur.flags_we = 1'b0;
      next_cur.done = 1'b0;
      fire = 1'b0;
      case (cur.st)
         BALU_IDLE:
         begin
            // A start is taken only here; a start while busy is ignored.
            if (start_i && two_cycle)
            begin
               next_cur.st = BALU_SECOND;
               next_cur.op = op_i;
               next_cur.a = dest_i;
               next_cur.b = source_i;
               next_cur.hi = pair_high_i;
               next_cur.fin = flags_i;
            end
            else if (start_i)
               fire = 1'b1;
         end
         BALU_SECOND:
         begin
            next_cur.st = BALU_IDLE;                  // [RULE_04]
            fire = 1'b1;
         end
         default:
            next_cur.st = BALU_IDLE;
      endcase

      if (fire)
      begin
         next_cur.flags = fin;
         next_cur.done = 1'b1;
         next_cur.flags_we = 1'b1;
         next_cur.wr_dest = 1'b1;
         case (op)
            OP_ADD, OP_ADD_CARRY:
            begin
               cin = (op == OP_ADD_CARRY) & fin[FLAG_C];
               r = a + b + {7'h00, cin};                // [RULE_01]
               next_cur.flags[FLAG_H] = (a[3] & b[3]) | (b[3] & ~r[3]) |
                                        (~r[3] & a[3]);
               next_cur.flags[FLAG_V] = (a[7] & b[7] & ~r[7]) |
                                        (~a[7] & ~b[7] & r[7]);
               next_cur.flags[FLAG_C] = (a[7] & b[7]) | (b[7] & ~r[7]) |
                                        (~r[7] & a[7]);
            end
            OP_SUB, OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_CONSTANT,
            OP_SUBTRACT_CONSTANT_WITH_BORROW, OP_SIGN_FLIP:
            begin
               sub_op = 1'b1;
            end
            OP_AND, OP_AND_WITH_CONSTANT, OP_TEST_VALUE:
            begin
               r = a & ((op == OP_TEST_VALUE) ? a : b);  // [RULE_06] [RULE_08]
               logic_op = 1'b1;
            end
            OP_OR, OP_OR_WITH_CONSTANT, OP_SET_BITS_BY_MASK:
            begin
               r = a | b;                              // [RULE_07] [RULE_09]
               logic_op = 1'b1;
            end
            OP_EXCLUSIVE_OR_REGS, OP_ZERO_REGISTER:
            begin
               r = a ^ ((op == OP_ZERO_REGISTER) ? a : b); // [RULE_07] [RULE_15]
               logic_op = 1'b1;
            end
            OP_CLEAR_BITS_BY_MASK:
            begin
               r = a & (BYTE_ONES - b);                 // [RULE_10]
               logic_op = 1'b1;
            end
            OP_BITWISE_INVERT:
            begin
               r = BYTE_ONES - a;                       // [RULE_13]
               logic_op = 1'b1;
               next_cur.flags[FLAG_C] = 1'b1;
            end
            OP_PLUS_ONE:
            begin
               // Carry is left alone so multi-byte loops can use it.
               r = a + BYTE_ONE;                        // [RULE_14]
               next_cur.flags[FLAG_V] = (r == BYTE_MIN_NEG);
            end
            OP_MINUS_ONE:
            begin
               r = a - BYTE_ONE;                        // [RULE_14]
               next_cur.flags[FLAG_V] = (r == BYTE_MAX_POS);
            end
            OP_SET_ALL_ONES:
            begin
               r = BYTE_ONES;                           // [RULE_15]
               next_cur.flags_we = 1'b0;
            end
            OP_ADD_IMMEDIATE_TO_PAIR, OP_SUBTRACT_IMMEDIATE_FROM_PAIR:
            begin
               next_cur.wr_dest = 1'b0;
               next_cur.wr_pair = 1'b1;
               if (op == OP_ADD_IMMEDIATE_TO_PAIR)
               begin
                  w = pair + {8'h00, b};                // [RULE_04]
                  next_cur.flags[FLAG_V] = ~hi[7] & w[15];
                  next_cur.flags[FLAG_C] = ~w[15] & hi[7];
               end
               else
               begin
                  w = pair - {8'h00, b};                // [RULE_05]
                  next_cur.flags[FLAG_V] = hi[7] & ~w[15];
                  next_cur.flags[FLAG_C] = w[15] & ~hi[7];
               end
               r = w[7:0];
               next_cur.res_hi = w[15:8];
               next_cur.flags[FLAG_N] = w[15];
               next_cur.flags[FLAG_Z] = (w == WORD_ZERO);
            end
            default:
            begin
               // Every remaining code is a multiply form.
               next_cur.wr_dest = 1'b0;
               next_cur.wr_prod = 1'b1;
               r = prod[7:0];                           // [RULE_11] [RULE_12]
               next_cur.res_hi = prod[15:8];
               next_cur.flags[FLAG_C] = prod_c;
               next_cur.flags[FLAG_Z] = prod_z;
            end
         endcase

         // Subtract forms share one borrow chain; negate is 0 - a.
         if (sub_op)
         begin
            x = (op == OP_SIGN_FLIP) ? BYTE_ZERO : a;
            y = (op == OP_SIGN_FLIP) ? a : b;
            chain = (op == OP_SUBTRACT_WITH_BORROW) ||
                    (op == OP_SUBTRACT_CONSTANT_WITH_BORROW);
            cin = chain & fin[FLAG_C];
            r = x - y - {7'h00, cin};                   // [RULE_02] [RULE_03] [RULE_13]
            next_cur.flags[FLAG_H] = (~x[3] & y[3]) | (y[3] & r[3]) |
                                     (r[3] & ~x[3]);
            next_cur.flags[FLAG_V] = (x[7] & ~y[7] & ~r[7]) |
                                     (~x[7] & y[7] & r[7]);
            next_cur.flags[FLAG_C] = (~x[7] & y[7]) | (y[7] & r[7]) |
                                     (r[7] & ~x[7]);
         end

         // Byte results but the all-ones load set N and Z; only borrow forms chain Z, so a
         // multi-byte difference reads zero only if every byte was.
         if (op < OP_ADD_IMMEDIATE_TO_PAIR && op != OP_SET_ALL_ONES)
         begin
            next_cur.flags[FLAG_N] = r[7];
            next_cur.flags[FLAG_Z] = (r == BYTE_ZERO) &
                                     (fin[FLAG_Z] | ~chain);
            if (logic_op)
               next_cur.flags[FLAG_V] = 1'b0;
         end
         // Sign tracks N and V wherever both were just written.
         if (op < OP_UNSIGNED_PRODUCT && op != OP_SET_ALL_ONES)
            next_cur.flags[FLAG_S] = next_cur.flags[FLAG_N] ^
                                     next_cur.flags[FLAG_V];
         next_cur.res = r;
      end
   end

   // ==========================================================
   // State register.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cur <= '{st: BALU_IDLE, default: '0};
      end
      else
      begin
         cur <= next_cur;
      end
   end

   // Outputs are fields of the registered record.
   assign result_o = cur.res;
   assign result_high_o = cur.res_hi;
   assign flags_o = cur.flags;
   assign write_dest_o = cur.wr_dest;
   assign write_pair_o = cur.wr_pair;
   assign write_product_o = cur.wr_prod;
   assign flags_write_o = cur.flags_we;
   assign busy_o = (cur.st == BALU_SECOND);
   assign done_o = cur.done;
endmodule : balu_core
`default_nettype wire

// ### include/balu_pkg.sv
// Package: operation codes, flag positions, sequencer states and constants for the ALU.
`default_nettype none
package balu_pkg;
   // ==========================================================
   // Operation codes presented by the instruction decoder.
   localparam logic [4:0] OP_ADD = 5'h00;
   localparam logic [4:0] OP_ADD_CARRY = 5'h01;
   localparam logic [4:0] OP_SUB = 5'h02;
   localparam logic [4:0] OP_SUBTRACT_WITH_BORROW = 5'h03;
   localparam logic [4:0] OP_SUBTRACT_CONSTANT = 5'h04;
   localparam logic [4:0] OP_SUBTRACT_CONSTANT_WITH_BORROW = 5'h05;
   localparam logic [4:0] OP_AND = 5'h06;
   localparam logic [4:0] OP_AND_WITH_CONSTANT = 5'h07;
   localparam logic [4:0] OP_OR = 5'h08;
   localparam logic [4:0] OP_OR_WITH_CONSTANT = 5'h09;
   localparam logic [4:0] OP_EXCLUSIVE_OR_REGS = 5'h0a;
   localparam logic [4:0] OP_BITWISE_INVERT = 5'h0b;
   localparam logic [4:0] OP_SIGN_FLIP = 5'h0c;
   localparam logic [4:0] OP_SET_BITS_BY_MASK = 5'h0d;
   localparam logic [4:0] OP_CLEAR_BITS_BY_MASK = 5'h0e;
   localparam logic [4:0] OP_PLUS_ONE = 5'h0f;
   localparam logic [4:0] OP_MINUS_ONE = 5'h10;
   localparam logic [4:0] OP_TEST_VALUE = 5'h11;
   localparam logic [4:0] OP_ZERO_REGISTER = 5'h12;
   localparam logic [4:0] OP_SET_ALL_ONES = 5'h13;
   localparam logic [4:0] OP_ADD_IMMEDIATE_TO_PAIR = 5'h14;
   localparam logic [4:0] OP_SUBTRACT_IMMEDIATE_FROM_PAIR = 5'h15;
   localparam logic [4:0] OP_UNSIGNED_PRODUCT = 5'h16;
   localparam logic [4:0] OP_MULTIPLY_SIGNED = 5'h17;
   localparam logic [4:0] OP_MULTIPLY_SIGNED_BY_UNSIGNED = 5'h18;
   localparam logic [4:0] OP_FRACTIONAL_MULTIPLY_UNSIGNED = 5'h19;
   localparam logic [4:0] OP_FRACTIONAL_MULTIPLY_SIGNED = 5'h1a;
   localparam logic [4:0] OP_FRACTIONAL_MULTIPLY_MIXED = 5'h1b;
   // ==========================================================
   // Status flag bit positions.
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   // ==========================================================
   // Byte constants and reset values.
   localparam logic [7:0] BYTE_ONES = 8'hff;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [7:0] BYTE_MIN_NEG = 8'h80;
   localparam logic [7:0] BYTE_MAX_POS = 8'h7f;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [4:0] OP_RESET = 5'h00;
   // ==========================================================
   // Sequencer states, one-hot.
   typedef enum logic [1:0]
   {
      BALU_IDLE = 2'b01,
      BALU_SECOND = 2'b10
   } balu_state_t;
endpackage : balu_pkg
`default_nettype wire

// ### rtl/balu_mult.sv
// Combinational 8x8 multiplier with signedness and fractional shift.
`default_nettype none
module balu_mult
   import balu_pkg::*;
(
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   input wire logic a_signed_i,
   input wire logic b_signed_i,
   input wire logic frac_i,
   output logic [15:0] product_o,
   output logic carry_o,
   output logic zero_o
);
   logic signed [8:0] a_ext;
   logic signed [8:0] b_ext;
   logic signed [17:0] raw;

   // ==========================================================
   // Extend each operand by its sign only when it is read as signed.
   assign a_ext = $signed({a_signed_i & a_i[7], a_i});
   assign b_ext = $signed({b_signed_i & b_i[7], b_i});
   assign raw = a_ext * b_ext;

   // Carry is the product's top bit before the fractional shift.
   always_comb
   begin
      carry_o = raw[15];                              // [RULE_11]
      product_o = frac_i ? {raw[14:0], 1'b0} : raw[15:0]; // [RULE_12]
      zero_o = (product_o == WORD_ZERO);
   end
endmodule : balu_mult
`default_nettype wire

// ### tb/balu_core_checker.sv
// Concurrent checks on the ALU core ports.
`default_nettype none
module balu_core_checker
   import balu_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic [4:0] op_i,
   input wire logic [7:0] dest_i,
   input wire logic [7:0] source_i,
   input wire logic [7:0] pair_high_i,
   input wire logic [7:0] flags_i,
   input wire logic [7:0] result_o,
   input wire logic [7:0] result_high_o,
   input wire logic [7:0] flags_o,
   input wire logic write_dest_o,
   input wire logic write_pair_o,
   input wire logic write_product_o,
   input wire logic flags_write_o,
   input wire logic busy_o,
   input wire logic done_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================
   // Operand capture
   logic take;
   logic [4:0] cap_op;
   logic [7:0] cap_dest;
   logic [7:0] cap_src;
   logic [7:0] cap_high;
   logic [7:0] cap_flags;

   // A refused request must not disturb the operands being judged.
   assign take = start_i && !busy_o;

   // Operands are held from the taking edge until the matching done.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cap_op <= OP_RESET;
         cap_dest <= 8'h00;
         cap_src <= 8'h00;
         cap_high <= 8'h00;
         cap_flags <= 8'h00;
      end
      else if (take)
      begin
         cap_op <= op_i;
         cap_dest <= dest_i;
         cap_src <= source_i;
         cap_high <= pair_high_i;
         cap_flags <= flags_i;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_single_latency: assert property (
      take && op_i < OP_ADD_IMMEDIATE_TO_PAIR |=> done_o && !busy_o)
      else $error("single cycle op late");
   a_two_cycle_wait: assert property (
      take && op_i >= OP_ADD_IMMEDIATE_TO_PAIR
      |=> busy_o && !done_o ##1 done_o && !busy_o)
      else $error("two cycle op timing wrong");
   a_busy_one_cycle: assert property (
      busy_o |=> !busy_o)
      else $error("busy held too long");
   a_add_sum: assert property (
      done_o && cap_op == OP_ADD |-> write_dest_o
      && result_o == cap_dest + cap_src)
      else $error("sum wrong");
   a_sub_borrow: assert property (
      done_o && cap_op == OP_SUB |-> result_o == cap_dest - cap_src
      && flags_o[FLAG_C] == (cap_src > cap_dest))
      else $error("difference or borrow wrong");
   a_const_diff: assert property (
      done_o && cap_op == OP_SUBTRACT_CONSTANT
      |-> result_o == cap_dest - cap_src)
      else $error("constant difference wrong");
   a_pair_sum: assert property (
      done_o && cap_op == OP_ADD_IMMEDIATE_TO_PAIR |-> write_pair_o
      && {result_high_o, result_o} == {cap_high, cap_dest} + cap_src)
      else $error("pair sum wrong");
   a_pair_diff: assert property (
      done_o && cap_op == OP_SUBTRACT_IMMEDIATE_FROM_PAIR
      |-> {result_high_o, result_o} == {cap_high, cap_dest} - cap_src)
      else $error("pair difference wrong");
   a_mask_clear: assert property (
      done_o && cap_op == OP_CLEAR_BITS_BY_MASK
      |-> result_o == (cap_dest & ~cap_src))
      else $error("masked clear wrong");
   a_product_pair: assert property (
      done_o && cap_op == OP_UNSIGNED_PRODUCT |-> write_product_o
      && {result_high_o, result_o} == cap_dest * cap_src)
      else $error("product wrong");
   a_inc_keeps_c: assert property (
      done_o && cap_op == OP_PLUS_ONE |-> result_o == cap_dest + 8'h01
      && flags_o[FLAG_C] == cap_flags[FLAG_C])
      else $error("increment wrong or carry changed");
   a_ones_no_flags: assert property (
      done_o && cap_op == OP_SET_ALL_ONES
      |-> result_o == 8'hff && !flags_write_o)
      else $error("all ones load wrong");
endmodule : balu_core_checker
`default_nettype wire

// ### tb/balu_regfile_model.sv
// Register file model that stores what the ALU core writes back.
`default_nettype none
module balu_regfile_model
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] result_i,
   input wire logic [7:0] result_high_i,
   input wire logic [7:0] flags_i,
   input wire logic write_dest_i,
   input wire logic write_pair_i,
   input wire logic write_product_i,
   input wire logic flags_write_i,
   output logic [7:0] dest_o,
   output logic [15:0] pair_o,
   output logic [15:0] product_o,
   output logic [7:0] status_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // Stores land on the edge where a strobe is seen, one cycle only.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         dest_o <= 8'h00;
         pair_o <= 16'h0000;
         product_o <= 16'h0000;
         status_o <= 8'h00;
      end
      else
      begin
         if (write_dest_i)
            dest_o <= result_i;
         if (write_pair_i)
            pair_o <= {result_high_i, result_i};
         if (write_product_i)
            product_o <= {result_high_i, result_i};
         if (flags_write_i)
            status_o <= flags_i;
      end
   end
endmodule : balu_regfile_model
`default_nettype wire

// ### tb/test_byte_arith_logic_unit.sv
// Self-checking bench for the ALU core.
`default_nettype none
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
   n_mismatch++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); \
   end end
module test_byte_arith_logic_unit
   import balu_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] M_AR = 8'h2f;
   localparam logic [7:0] M_ZNV = 8'h0e;
   localparam logic [7:0] M_ZCNV = 8'h0f;
   localparam logic [7:0] M_ZC = 8'h03;
   localparam logic [2:0] W_D = 3'h4;
   localparam logic [2:0] W_P = 3'h2;
   localparam logic [2:0] W_M = 3'h1;
   logic clk_i, rst_n_i, start_i;
   logic [4:0] op_i;
   logic [7:0] dest_i, source_i, pair_high_i, flags_i, cfl, ph;
   logic [7:0] result_o, result_high_o, flags_o, rf_dest, rf_status;
   logic write_dest_o, write_pair_o, write_product_o, flags_write_o;
   logic busy_o, done_o;
   logic [15:0] rf_pair, rf_prod;
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;

   balu_core u_balu_core (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .start_i(start_i), .op_i(op_i), .dest_i(dest_i),
      .source_i(source_i), .pair_high_i(pair_high_i), .flags_i(flags_i),
      .result_o(result_o), .result_high_o(result_high_o),
      .flags_o(flags_o), .write_dest_o(write_dest_o),
      .write_pair_o(write_pair_o), .write_product_o(write_product_o),
      .flags_write_o(flags_write_o), .busy_o(busy_o), .done_o(done_o));
   balu_regfile_model u_balu_regfile_model (.clk_i(clk_i),
      .rst_n_i(rst_n_i), .result_i(result_o),
      .result_high_i(result_high_o), .flags_i(flags_o),
      .write_dest_i(write_dest_o), .write_pair_i(write_pair_o),
      .write_product_i(write_product_o), .flags_write_i(flags_write_o),
      .dest_o(rf_dest), .pair_o(rf_pair), .product_o(rf_prod),
      .status_o(rf_status));

   // ==========================================================
   // Clock and hang guard
   always #2.5 clk_i = ~clk_i;

   // About 110 cycles are needed; the limit is generous.
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_mismatch++;
         results();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic results();
      if (n_mismatch == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results

   task automatic tick();
      @(posedge clk_i);
      #1;
   endtask : tick

   // One operation: expected flags are the given ones, S worked out as N^V.
   task automatic run(input logic [4:0] op, input logic [7:0] d, s,
      input logic [15:0] r, input logic [7:0] ef, m, input logic [2:0] wr);
      logic [7:0] mk;
      logic [7:0] e;
      int n;
      int two;
      mk = m[FLAG_N] ? (m | 8'h10) : m;
      e = ef;
      e[FLAG_S] = ef[FLAG_N] ^ ef[FLAG_V];
      e = (cfl & ~mk) | (e & mk);
      two = (op >= OP_ADD_IMMEDIATE_TO_PAIR) ? 1 : 0;
      tick();
      start_i = 1'b1;
      op_i = op;
      dest_i = d;
      source_i = s;
      pair_high_i = ph;
      flags_i = cfl;
      tick();
      start_i = 1'b0;
      n = 0;
      while (done_o !== 1'b1 && n < 4)
      begin
         tick();
         n++;
      end
      `CHK("latency", two, n)
      `CHK("result", r[7:0], result_o)
      if (wr != W_D)
         `CHK("result high", r[15:8], result_high_o)
      `CHK("strobes", wr, {write_dest_o, write_pair_o, write_product_o})
      `CHK("flag write", mk != 8'h00, flags_write_o)
      if (mk != 8'h00)
         `CHK("flags", e, flags_o)
      tick();
      if (wr == W_D)
         `CHK("stored", r[7:0], rf_dest)
      else
         `CHK("stored", r, wr == W_P ? rf_pair : rf_prod)
      if (mk != 8'h00)
         `CHK("stored flags", e, rf_status)
   endtask : run

   // ==========================================================
   // Scenarios
   task automatic arith_ops();
      cfl = 8'hc0;
      run(OP_ADD, 8'h0f, 8'h01, 16'h0010, 8'h20, M_AR, W_D);
      cfl = 8'hc1;
      run(OP_ADD_CARRY, 8'hff, 8'h00, 16'h0000, 8'h23, M_AR, W_D);
      cfl = 8'hc0;
      run(OP_SUB, 8'h10, 8'h20, 16'h00f0, 8'h05, M_AR, W_D);
      cfl = 8'hc3;
      run(OP_SUBTRACT_WITH_BORROW, 8'h01, 8'h00,
         16'h0000, 8'h02, M_AR, W_D);
      cfl = 8'hc0;
      run(OP_SUBTRACT_CONSTANT, 8'h80, 8'h01,
         16'h007f, 8'h28, M_AR, W_D);
      cfl = 8'hc1;
      run(OP_SUBTRACT_CONSTANT_WITH_BORROW, 8'h00, 8'h00,
         16'h00ff, 8'h25, M_AR, W_D);
   endtask : arith_ops

   task automatic word_ops();
      cfl = 8'hc0;
      ph = 8'h00;
      run(OP_ADD_IMMEDIATE_TO_PAIR, 8'hff, 8'h01,
         16'h0100, 8'h00, M_ZCNV, W_P);
      run(OP_SUBTRACT_IMMEDIATE_FROM_PAIR, 8'h00, 8'h01,
         16'hffff, 8'h05, M_ZCNV, W_P);
   endtask : word_ops

   // V starts set so that every logic operation but the all-ones load must be seen to clear it.
   task automatic logic_ops();
      cfl = 8'hc8;
      run(OP_AND, 8'h5a, 8'h0f, 16'h000a, 8'h00, M_ZNV, W_D);
      run(OP_AND_WITH_CONSTANT, 8'hf0, 8'h0f,
         16'h0000, 8'h02, M_ZNV, W_D);
      run(OP_OR, 8'h80, 8'h01, 16'h0081, 8'h04, M_ZNV, W_D);
      run(OP_OR_WITH_CONSTANT, 8'h00, 8'h00,
         16'h0000, 8'h02, M_ZNV, W_D);
      run(OP_EXCLUSIVE_OR_REGS, 8'hff, 8'h0f,
         16'h00f0, 8'h04, M_ZNV, W_D);
      run(OP_TEST_VALUE, 8'h80, 8'h00, 16'h0080, 8'h04, M_ZNV, W_D);
      run(OP_SET_BITS_BY_MASK, 8'h01, 8'h80,
         16'h0081, 8'h04, M_ZNV, W_D);
      run(OP_CLEAR_BITS_BY_MASK, 8'hff, 8'h0f,
         16'h00f0, 8'h04, M_ZNV, W_D);
      run(OP_ZERO_REGISTER, 8'h5a, 8'h00,
         16'h0000, 8'h02, M_ZNV, W_D);
      run(OP_SET_ALL_ONES, 8'h12, 8'h00, 16'h00ff, 8'h00, 8'h00, W_D);
   endtask : logic_ops

   task automatic unary_ops();
      cfl = 8'hc0;
      run(OP_BITWISE_INVERT, 8'h55, 8'h00,
         16'h00aa, 8'h05, M_ZCNV, W_D);
      run(OP_SIGN_FLIP, 8'h01, 8'h00, 16'h00ff, 8'h25, M_AR, W_D);
      cfl = 8'hc1;
      run(OP_PLUS_ONE, 8'h7f, 8'h00, 16'h0080, 8'h0c, M_ZNV, W_D);
      cfl = 8'hc0;
      run(OP_MINUS_ONE, 8'h80, 8'h00, 16'h007f, 8'h08, M_ZNV, W_D);
   endtask : unary_ops

   task automatic mul_ops();
      cfl = 8'hc0;
      run(OP_UNSIGNED_PRODUCT, 8'hff, 8'hff,
         16'hfe01, 8'h01, M_ZC, W_M);
      run(OP_UNSIGNED_PRODUCT, 8'h00, 8'h37,
         16'h0000, 8'h02, M_ZC, W_M);
      run(OP_MULTIPLY_SIGNED, 8'hff, 8'hff,
         16'h0001, 8'h00, M_ZC, W_M);
      run(OP_MULTIPLY_SIGNED_BY_UNSIGNED, 8'hff, 8'hff,
         16'hff01, 8'h01, M_ZC, W_M);
      run(OP_FRACTIONAL_MULTIPLY_UNSIGNED, 8'h80, 8'h80,
         16'h8000, 8'h00, M_ZC, W_M);
      run(OP_FRACTIONAL_MULTIPLY_SIGNED, 8'h80, 8'h80,
         16'h8000, 8'h00, M_ZC, W_M);
      run(OP_FRACTIONAL_MULTIPLY_MIXED, 8'hc0, 8'h80,
         16'hc000, 8'h01, M_ZC, W_M);
   endtask : mul_ops

   // Two additions on consecutive edges, each answered on its own.
   task automatic back_to_back();
      tick();
      start_i = 1'b1;
      op_i = OP_ADD;
      dest_i = 8'h01;
      source_i = 8'h02;
      tick();
      `CHK("first sum", 8'h03, result_o)
      dest_i = 8'h10;
      source_i = 8'h20;
      tick();
      start_i = 1'b0;
      `CHK("second sum", 8'h30, result_o)
      `CHK("second done", 1'b1, done_o)
   endtask : back_to_back

   // An addition offered while a product is under way must be dropped.
   task automatic refuse_busy();
      tick();
      start_i = 1'b1;
      op_i = OP_UNSIGNED_PRODUCT;
      dest_i = 8'h02;
      source_i = 8'h03;
      tick();
      op_i = OP_ADD;
      dest_i = 8'h11;
      tick();
      start_i = 1'b0;
      `CHK("product", 16'h0006, {result_high_o, result_o})
      tick();
      `CHK("refused done", 1'b0, done_o)
      `CHK("held low byte", 8'h06, result_o)
   endtask : refuse_busy

   // ==========================================================
   // Main sequence
   initial
   begin
      clk_i = 1'b0;
      rst_n_i = 1'b0;
      start_i = 1'b0;
      op_i = OP_RESET;
      dest_i = 8'h00;
      source_i = 8'h00;
      pair_high_i = 8'h00;
      flags_i = 8'h00;
      cfl = 8'hc0;
      ph = 8'h00;
      repeat (8) @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      arith_ops();
      word_ops();
      logic_ops();
      unary_ops();
      mul_ops();
      back_to_back();
      refuse_busy();
      results();
   end
endmodule : test_byte_arith_logic_unit

bind balu_core balu_core_checker u_balu_core_checker (.clk_i(clk_i),
   .rst_n_i(rst_n_i), .start_i(start_i), .op_i(op_i), .dest_i(dest_i),
   .source_i(source_i), .pair_high_i(pair_high_i), .flags_i(flags_i),
   .result_o(result_o), .result_high_o(result_high_o),
   .flags_o(flags_o), .write_dest_o(write_dest_o),
   .write_pair_o(write_pair_o), .write_product_o(write_product_o),
   .flags_write_o(flags_write_o), .busy_o(busy_o), .done_o(done_o));
`undef CHK
`default_nettype wire
